// File: hdl/srcc_top.sv
// downstream reset generation and reference clock buffer enable
// assumes RESETN is a power-on reset; system reset, strap and presence pins are asynchronous
`timescale 1ns/1ps
module srcc_top
   import srcc_pkg::*;
#(
   parameter int PLUG_RST_CYCLES = PLUG_RESET_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic SYSTEM_RESET_N,
   input wire logic CLOCK_BUFFER_POWERDOWN,
   input wire logic [NUM_DOWN:1] PRESENT_N,
   input wire logic BUFFER_REFCLK_IN_POS,
   input wire logic BUFFER_REFCLK_IN_NEG,
   output logic [NUM_DOWN:1] DOWNSTREAM_RESET_N,
   output logic [NUM_DOWN:1] PLUG_SEEN,
   output logic CLOCK_BUFFER_ENABLED,
   output logic [NUM_CLK_OUT-1:0] BUFFERED_REFCLK_OUT_POS,
   output logic [NUM_CLK_OUT-1:0] BUFFERED_REFCLK_OUT_NEG
);

   // -------------------------------------------------------------
   // functions
   // -------------------------------------------------------------
   // accept a new level only where the last two sync stages agree
   function automatic logic [SYNC_W-1:0] agree(input logic [SYNC_W-1:0] cur,
                                               input logic [SYNC_W-1:0] s2,
                                               input logic [SYNC_W-1:0] s3);
      agree = (s2 & s3) | (cur & (s2 | s3));
   endfunction

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
   logic [SYNC_W-1:0] pins, filt_d;

   assign pins = {PRESENT_N, CLOCK_BUFFER_POWERDOWN, SYSTEM_RESET_N};
   assign filt_d = agree(filt_q, s2_q, s3_q);

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         filt_q <= SYNC_RST;
      end else if (CLK_EN) begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   logic sys_rst;
   logic [NUM_DOWN-1:0] present, present_q, plugged;

   assign sys_rst = ~filt_q[SYNC_SYSRST_BIT];
   assign present = ~filt_q[SYNC_PRSNT_LSB +: NUM_DOWN];
   // newly present slot seen outside system reset
   assign plugged = present & ~present_q & {NUM_DOWN{~sys_rst}};

   // -------------------------------------------------------------
   // per downstream port reset (port 0 is upstream, has none)
   // -------------------------------------------------------------
   localparam logic [PLUG_CNT_W-1:0] PLUG_LOAD = PLUG_CNT_W'(PLUG_RST_CYCLES);

   logic [PLUG_CNT_W-1:0] cnt_q [NUM_DOWN];
   logic [PLUG_CNT_W-1:0] cnt_d [NUM_DOWN];
   logic [NUM_DOWN-1:0] busy, down_rst_n_d, down_rst_n_q, seen_q, seen_d;

   genvar g;
   generate
      for (g = 0; g < NUM_DOWN; g++) begin : g_port
         assign busy[g] = (cnt_q[g] != PLUG_CNT_RST);
         assign cnt_d[g] = sys_rst ? PLUG_CNT_RST :
                           plugged[g] ? PLUG_LOAD :
                           busy[g] ? cnt_q[g] - PLUG_CNT_W'(1) : cnt_q[g];
         // low while system reset or plug timer runs
         assign down_rst_n_d[g] = ~sys_rst & ~plugged[g] & ~busy[g];

         always_ff @(posedge SYS_CLK or negedge RESETN) begin
            if (!RESETN) begin
               cnt_q[g] <= PLUG_CNT_RST;
            end else if (CLK_EN) begin
               cnt_q[g] <= cnt_d[g];
            end
         end
      end
   endgenerate

   // sticky flags survive system reset
   assign seen_d = seen_q | plugged;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         present_q <= DOWN_RST_N_RST;
         down_rst_n_q <= DOWN_RST_N_RST;
         seen_q <= PLUG_SEEN_RST;
      end else if (CLK_EN) begin
         present_q <= sys_rst ? DOWN_RST_N_RST | present : present;
         down_rst_n_q <= down_rst_n_d;
         seen_q <= seen_d;
      end
   end

   assign DOWNSTREAM_RESET_N = down_rst_n_q;
   assign PLUG_SEEN = seen_q;

   // -------------------------------------------------------------
   // reference clock buffer
   // -------------------------------------------------------------
   logic clk_en_q;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         clk_en_q <= CLK_EN_RST;
      end else if (CLK_EN) begin
         clk_en_q <= ~filt_q[SYNC_PD_BIT];
      end
   end

   assign CLOCK_BUFFER_ENABLED = clk_en_q;
   // gated pass-through: the clock itself cannot be re-timed by a slower clock
   assign BUFFERED_REFCLK_OUT_POS = {NUM_CLK_OUT{BUFFER_REFCLK_IN_POS & clk_en_q}};
   assign BUFFERED_REFCLK_OUT_NEG = {NUM_CLK_OUT{BUFFER_REFCLK_IN_NEG & clk_en_q}};

endmodule

// File: shared/srcc_pkg.sv
// constants for the switch reset and reference clock buffer control block
// assumes one 50 MHz system clock and pins arriving from outside its domain
//
// Function
// - While system reset is low, the plug timers and downstream resets are cleared; the sticky plug-seen flags and the buffer enable are not.
// - Every downstream reset output is driven low whenever system reset is low.
// - A downstream port's reset is also driven low for a time after a device is plugged in.
// - There are three downstream resets, one for each of downstream ports one, two and three.
// - Port zero is the upstream port and has no downstream reset; ports one to three do.
// - With the power-down strap high the clock buffer and its outputs are off, low means on.
// - When on, the buffer passes the 100 MHz clock from its own input pair to its output pairs.
package srcc_pkg;
   // -------------------------------------------------------------
   // ports and widths
   // -------------------------------------------------------------
   localparam int UPSTREAM_PORT = 0;
   localparam int FIRST_DOWN_PORT = 1;
   localparam int LAST_DOWN_PORT = 3;
   localparam int NUM_DOWN = 3;
   localparam int NUM_CLK_OUT = 4;
   localparam int SYNC_W = 5;
   // sync vector field positions
   localparam int SYNC_SYSRST_BIT = 0;
   localparam int SYNC_PD_BIT = 1;
   localparam int SYNC_PRSNT_LSB = 2;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int SYS_CLK_HZ = 50000000;
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int REFCLK_OUT_MHZ = 100;
   localparam int PLUG_RESET_TIME_US = 100;
   localparam int PLUG_RESET_CYCLES = (PLUG_RESET_TIME_US * (SYS_CLK_HZ / 1000000));
   localparam int PLUG_CNT_W = 13;
   // -------------------------------------------------------------
   // reset values (sysrst asserted, strap powered down, slots empty)
   // -------------------------------------------------------------
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1E;
   localparam logic [NUM_DOWN-1:0] DOWN_RST_N_RST = 3'h0;
   localparam logic [NUM_DOWN-1:0] PLUG_SEEN_RST = 3'h0;
   localparam logic [PLUG_CNT_W-1:0] PLUG_CNT_RST = 13'h0000;
   localparam logic CLK_EN_RST = 1'b0;
endpackage

// File: testbench/srcc_partner.sv
// far side: free-running 100 MHz buffer reference pair
// assumes the bench ties it to the buffer input pins
`timescale 1ns/1ps
module srcc_partner (
   output logic refclk_pos,
   output logic refclk_neg
);
   // offset so edges never meet bench sample points
   initial begin
      refclk_pos = 1'b0;
      #2;
      forever #5 refclk_pos = ~refclk_pos;
   end
   assign refclk_neg = ~refclk_pos;
endmodule

// File: testbench/srcc_top_asserts.sv
// checker on srcc_top ports
// assumes one clock domain, bound below
`timescale 1ns/1ps
module srcc_chk
   import srcc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic SYSTEM_RESET_N,
   input wire logic CLOCK_BUFFER_POWERDOWN,
   input wire logic [NUM_DOWN:1] PRESENT_N,
   input wire logic BUFFER_REFCLK_IN_POS,
   input wire logic BUFFER_REFCLK_IN_NEG,
   input wire logic [NUM_DOWN:1] DOWNSTREAM_RESET_N,
   input wire logic [NUM_DOWN:1] PLUG_SEEN,
   input wire logic CLOCK_BUFFER_ENABLED,
   input wire logic [NUM_CLK_OUT-1:0] BUFFERED_REFCLK_OUT_POS,
   input wire logic [NUM_CLK_OUT-1:0] BUFFERED_REFCLK_OUT_NEG
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   a_sysrst_low: assert property ((!SYSTEM_RESET_N && CLK_EN) [*7] |-> !DOWNSTREAM_RESET_N)
      else $error("downstream reset high in system reset");
   a_plug_own_rst: assert property (
      (PLUG_SEEN & ~$past(PLUG_SEEN) & DOWNSTREAM_RESET_N) == 0)
      else $error("plug-in did not reset its port");
   a_plug_rst_len: assert property ($rose(PLUG_SEEN[1]) |-> !DOWNSTREAM_RESET_N[1] [*8])
      else $error("plug-in reset too short");
   a_release_cond: assert property ((DOWNSTREAM_RESET_N & ~$past(DOWNSTREAM_RESET_N)) != 0
      |-> $past(SYSTEM_RESET_N, 4))
      else $error("reset released in system reset");
   a_pd_off: assert property ((CLOCK_BUFFER_POWERDOWN && CLK_EN) [*7]
      |-> !CLOCK_BUFFER_ENABLED)
      else $error("buffer on while strap high");
   a_pd_on: assert property ((!CLOCK_BUFFER_POWERDOWN && CLK_EN) [*7]
      |-> CLOCK_BUFFER_ENABLED)
      else $error("buffer off while strap low");
   a_clk_gate: assert property ({BUFFERED_REFCLK_OUT_POS, BUFFERED_REFCLK_OUT_NEG} ==
      {{NUM_CLK_OUT{BUFFER_REFCLK_IN_POS & CLOCK_BUFFER_ENABLED}},
      {NUM_CLK_OUT{BUFFER_REFCLK_IN_NEG & CLOCK_BUFFER_ENABLED}}})
      else $error("clock outputs do not follow gated input");
   a_seen_sticky: assert property ((PLUG_SEEN | ~$past(PLUG_SEEN)) == 3'h7)
      else $error("sticky plug flag cleared");
   a_seen_in_rst: assert property ((!SYSTEM_RESET_N && CLK_EN) [*7] |-> $stable(PLUG_SEEN))
      else $error("plug flag set in system reset");
   c_plug: cover property ($rose(PLUG_SEEN[1]));
   c_release: cover property ($rose(DOWNSTREAM_RESET_N[2]));
   c_buf_on: cover property ($rose(CLOCK_BUFFER_ENABLED));
endmodule
bind srcc_top srcc_chk u_chk (.*);

// File: testbench/srcc_top_test.sv
// bench: system reset, plug-ins, strap, power-on reset
// assumes srcc_partner drives the buffer reference
`timescale 1ns/1ps
module srcc_top_test
   import srcc_pkg::*;
;
   localparam int PR = 20;
   logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, srst_n = 1'b0, pd = 1'b1, b;
   logic [3:1] prs_n = 3'h0, drn, seen;
   logic cbe, rp, rn;
   logic [3:0] op, on;
   int n_fail = 0, cmp_count = 0, cycles = 0, exp_seen = 0, p, k;
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (++cycles == 3000) begin
      n_fail++;
      results();
   end
   srcc_partner u_far (.refclk_pos(rp), .refclk_neg(rn));
   srcc_top #(.PLUG_RST_CYCLES(PR)) u_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .CLK_EN(clk_en),
      .SYSTEM_RESET_N(srst_n), .CLOCK_BUFFER_POWERDOWN(pd), .PRESENT_N(prs_n),
      .BUFFER_REFCLK_IN_POS(rp), .BUFFER_REFCLK_IN_NEG(rn), .DOWNSTREAM_RESET_N(drn),
      .PLUG_SEEN(seen), .CLOCK_BUFFER_ENABLED(cbe), .BUFFERED_REFCLK_OUT_POS(op),
      .BUFFERED_REFCLK_OUT_NEG(on));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic results();
      $display("checks %0d failures %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(66849));
      cyc(12);
      @(posedge sys_clk) resetn <= 1'b1;
      @(posedge sys_clk) prs_n <= 3'h7;
      cyc(10);
      chk(drn, 8'h00);
      chk(cbe, 8'h00);
      // plug during system reset is not a plug-in
      @(posedge sys_clk) prs_n <= 3'h0;
      cyc(10);
      chk(seen, 8'h00);
      @(posedge sys_clk) {srst_n, pd} <= 2'h2;
      cyc(10);
      chk(drn, 8'h07);
      chk(op, {4'h0, {4{rp}}});
      k = $urandom_range(2);
      for (int i = 0; i < 3; i++) begin
         p = (i + k) % 3 + 1;
         @(posedge sys_clk) prs_n[p] <= 1'b1;
         cyc(8);
         @(posedge sys_clk) prs_n[p] <= 1'b0;
         exp_seen |= 1 << (p - 1);
         cyc(8);
         chk(drn, 8'(7 & ~(1 << (p - 1))));
         chk(seen, 8'(exp_seen));
         // frozen clock enable stretches the plug reset
         @(posedge sys_clk) clk_en <= (i != 0);
         cyc(PR);
         chk(drn[p], 8'(i != 0));
         @(posedge sys_clk) clk_en <= 1'b1;
         cyc(PR + 4);
         chk(drn, 8'h07);
      end
      repeat (4) begin
         b = $urandom_range(1);
         @(posedge sys_clk) pd <= b;
         cyc(10);
         chk(cbe, {7'h0, ~b});
         chk(on, b ? 8'h00 : {4'h0, {4{rn}}});
      end
      @(posedge sys_clk) resetn <= 1'b0;
      cyc(2);
      chk(seen, 8'h00);
      chk(drn, 8'h00);
      results();
   end
endmodule
